/* File: core/atb_defs.vh */
// Constants of the advanced timer time base
`ifndef ATB_DEFS_VH
`define ATB_DEFS_VH
// Register byte offsets
`define ATB_CTL_OFS 12'h000
`define ATB_SMCFG_OFS 12'h004
`define ATB_SWEV_OFS 12'h008
`define ATB_STAT_OFS 12'h00C
`define ATB_CNT_OFS 12'h010
`define ATB_PSC_OFS 12'h014
`define ATB_CAR_OFS 12'h018
`define ATB_REPETITION_COUNT_OFS 12'h01C
// Control field positions
`define ATB_CTL_CEN 0
`define ATB_CTL_UPDATE_DISABLE 1
`define ATB_CTL_DIR 2
`define ATB_CTL_CAM_LO 3
`define ATB_CTL_CAM_HI 4
`define ATB_SMC_LO 0
`define ATB_SMC_HI 2
`define ATB_EXT_CLOCK_MODE1_EN 3
`define ATB_TRG_LO 4
`define ATB_TRG_HI 7
`define ATB_SWEV_UPG 0
`define ATB_STAT_UPDATE_INT_FLAG 0
// Slave modes and trigger codes
`define ATB_SMC_INT 3'h0
`define ATB_SMC_EXT0 3'h7
`define ATB_TRG_ITI_MAX 4'h3
`define ATB_TRG_ETI 4'h7
`define ATB_TRG_CH_A_LO 4'h4
`define ATB_TRG_CH_A_HI 4'h6
`define ATB_TRG_CH_B_LO 4'h8
`define ATB_TRG_CH_B_HI 4'hD
`define ATB_TRG_CH_B_BASE 4'h5
// Reset values
`define ATB_CAR_RST 16'hFFFF
`define ATB_ZERO16 16'h0000
`define ATB_ONE16 16'h0001
`endif

/* File: core/atb_time_base.v */
// Advanced timer time base: clock select, prescaler, counter, repetition
// Behaviour
// - Slave modes 0, 4, 5, 6 clock the prescaler from the internal clock unless mode1 bit set.
// - Slave modes 1, 2, 3, 7 clock the prescaler from trigger select unless mode1 bit set.
// - Mode 7 with trigger 4-6 or 8-D counts chosen channel pin edges.
// - Mode 7 with trigger 0-3 counts internal trigger rising edges.
// - External trigger clocks when mode1 bit set or mode 7 trigger 7.
// - One prescaler pulse per rising edge of filtered external trigger.
// - Prescaler divides by 1 through 65536.
// - New prescaler value takes effect at next update event.
// - Up mode counts 0 to reload, wraps to 0, raises overflow.
// - Down mode counts reload to 0, reloads, raises underflow.
// - Center mode counts up then down; direction bit reads current direction.
// - Center overflow at reload minus one, underflow at one.
// - Center mode sets update flag on overflow or underflow.
// - Up mode soft update clears counter and makes an update.
// - Down mode soft update loads reload value and makes an update.
// - Center mode soft update clears counter, any direction.
// - Update disable bit suppresses update events.
// - Update copies repetition, reload and prescaler preloads to shadows.
// - Counter update once every N+1 counter cycles.
// - Repetition decrements on overflow and underflow; soft update reloads it.
// - New repetition count takes effect at next update.
// - Odd repetition in center mode: update phase follows load moment.
// - Counter and prescaler are 16-bit unsigned.
`include "atb_defs.vh"
`default_nettype none
module atb_time_base #(
  parameter CW = 16,
  parameter NCH = 8,
  parameter NITI = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // External clock sources (asynchronous)
  input wire [NCH-1:0] ext_channel_pin_i,
  input wire [NITI-1:0] internal_trigger_in_i,
  input wire ext_trigger_input_i,
  // Events
  output reg overflow_o,
  output reg underflow_o,
  output reg update_event_o,
  output wire counter_clock_o
);

  // ************************************************************
  // Register state
  // ************************************************************
  reg counter_enable_bit_ff;
  reg update_disable_ff;
  reg dir_ff;
  reg [1:0] center_align_select_ff;
  reg [2:0] slave_mode_select_ff;
  reg ext_clock_mode1_en_ff;
  reg [3:0] trigger_source_select_ff;
  reg [7:0] edge_falling_ff;
  reg update_int_flag_ff;
  reg [CW-1:0] cnt_ff;
  reg [CW-1:0] psc_pre_ff;
  reg [CW-1:0] psc_act_ff;
  reg [CW-1:0] psc_cnt_ff;
  reg [CW-1:0] car_pre_ff;
  reg [CW-1:0] car_act_ff;
  reg [7:0] rep_pre_ff;
  reg [7:0] rep_act_ff;
  reg [7:0] rep_cnt_ff;
  reg [31:0] rdata_ff;

  wire wr_en = psel_i & penable_i & pwrite_i;
  wire rd_en = psel_i & ~penable_i & ~pwrite_i;
  wire center = |center_align_select_ff;
  wire soft_update_generate = wr_en & (paddr_i == `ATB_SWEV_OFS) & pwdata_i[`ATB_SWEV_UPG];
  // Reads are captured in the setup cycle so the access phase never waits;
  // writes land in the access cycle. Unmapped offsets read as zero and
  // ignore writes, with no slave error.

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam NS = NCH + NITI + 1;
  wire [NS-1:0] raw_in = {ext_trigger_input_i, internal_trigger_in_i, ext_channel_pin_i};
  reg [NS-1:0] sync1_ff;
  reg [NS-1:0] sync2_ff;
  reg [NS-1:0] sync3_ff;
  // Two stages against metastability, third for edge detection
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_ff <= {NS{1'b0}};
      sync2_ff <= {NS{1'b0}};
      sync3_ff <= {NS{1'b0}};
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end
  wire [NS-1:0] rise = sync2_ff & ~sync3_ff;
  wire [NS-1:0] fall = ~sync2_ff & sync3_ff;
  // Edges reach the counter three clocks after the pin moves; pulses
  // narrower than one clock may be lost, so sources must be slower.
  // Reset drops the chain low, so a pin idling high shows one false rise
  // just after reset; harmless while counting is still off.

  // ************************************************************
  // Clock source select
  // ************************************************************
  // With the mode1 bit clear, slave modes 4 to 6 leave the internal clock driving the divider;
  // modes 1 to 3 count rises of the trigger source.
  reg src_tick;
  reg [3:0] ch_idx;
  always @* begin
    src_tick = 1'b0;
    ch_idx = 4'h0;
    if (ext_clock_mode1_en_ff) begin
      src_tick = rise[NS-1];
    end else if (slave_mode_select_ff == `ATB_SMC_EXT0) begin
      if (trigger_source_select_ff <= `ATB_TRG_ITI_MAX) begin
        src_tick = rise[NCH + trigger_source_select_ff[1:0]];
      end else if (trigger_source_select_ff == `ATB_TRG_ETI) begin
        src_tick = rise[NS-1];
      end else if (trigger_source_select_ff <= `ATB_TRG_CH_A_HI) begin
        ch_idx = trigger_source_select_ff - `ATB_TRG_CH_A_LO;
        src_tick = edge_falling_ff[ch_idx[2:0]] ? fall[ch_idx[2:0]] : rise[ch_idx[2:0]];
      end else if (trigger_source_select_ff <= `ATB_TRG_CH_B_HI) begin
        // Codes 8 to D fold onto pin index code minus five; an index past
        // the last pin wraps onto the low pins, a known limitation.
        ch_idx = trigger_source_select_ff - `ATB_TRG_CH_B_BASE;
        src_tick = edge_falling_ff[ch_idx[2:0]] ? fall[ch_idx[2:0]] : rise[ch_idx[2:0]];
      end
    end else if (slave_mode_select_ff == 3'h1 || slave_mode_select_ff == 3'h2 ||
                 slave_mode_select_ff == 3'h3) begin
      src_tick = (trigger_source_select_ff <= `ATB_TRG_ITI_MAX) ?
                 rise[NCH + trigger_source_select_ff[1:0]] : rise[NS-1];
    end else begin
      src_tick = 1'b1;
    end
  end

  // ************************************************************
  // Prescaler and counter
  // ************************************************************
  // The divider only steps on source ticks, so with an external source
  // the prescaler divides edges, not timer clocks.
  // divide by psc plus one
  wire psc_wrap = (psc_cnt_ff == psc_act_ff);
  wire cnt_tick = counter_enable_bit_ff & src_tick & psc_wrap;
  assign counter_clock_o = cnt_tick;
  reg nxt_ovf;
  reg nxt_udf;
  reg [CW-1:0] nxt_cnt;
  reg nxt_dir;
  // Center mode turns at the reload value and at zero; a soft update
  // restarts it counting up. Up and down modes never use the turn logic.
  always @* begin
    nxt_ovf = 1'b0;
    nxt_udf = 1'b0;
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    if (cnt_tick) begin
      if (center) begin
        if (!dir_ff) begin
          nxt_cnt = cnt_ff + `ATB_ONE16;
          nxt_ovf = (cnt_ff == car_act_ff - `ATB_ONE16);
          if (cnt_ff + `ATB_ONE16 >= car_act_ff) nxt_dir = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - `ATB_ONE16;
          nxt_udf = (cnt_ff == `ATB_ONE16);
          if (cnt_ff <= `ATB_ONE16) nxt_dir = 1'b0;
        end
      end else if (!dir_ff) begin
        nxt_ovf = (cnt_ff >= car_act_ff);
        nxt_cnt = nxt_ovf ? `ATB_ZERO16 : cnt_ff + `ATB_ONE16;
      end else begin
        nxt_udf = (cnt_ff == `ATB_ZERO16);
        nxt_cnt = nxt_udf ? car_act_ff : cnt_ff - `ATB_ONE16;
      end
    end
  end
  // Repetition runs down on each event and reloads from the preload (the active
  // copy if updates are disabled) when it reaches zero, where the update fires.
  // update once repetition exhausted
  wire rep_zero = (rep_cnt_ff == 8'h00);
  wire cnt_upd = (nxt_ovf | nxt_udf) & rep_zero;
  wire upd = ~update_disable_ff & (soft_update_generate | cnt_upd);

  // A soft update blocked by update disable also skips the restart,
  // so counter and repetition carry on untouched.
  // Counter, prescaler, shadows; soft update has priority
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= `ATB_ZERO16;
      psc_cnt_ff <= `ATB_ZERO16;
      psc_act_ff <= `ATB_ZERO16;
      car_act_ff <= `ATB_CAR_RST;
      rep_act_ff <= 8'h00;
      rep_cnt_ff <= 8'h00;
      dir_ff <= 1'b0;
      overflow_o <= 1'b0;
      underflow_o <= 1'b0;
      update_event_o <= 1'b0;
    end else begin
      overflow_o <= nxt_ovf;
      underflow_o <= nxt_udf;
      update_event_o <= upd;
      if (soft_update_generate && !update_disable_ff) begin
        cnt_ff <= (dir_ff && !center) ? car_pre_ff : `ATB_ZERO16;
        psc_cnt_ff <= `ATB_ZERO16;
        // soft update reloads repetition; phase restarts here
        rep_cnt_ff <= rep_pre_ff;
        if (center) dir_ff <= 1'b0;
      end else begin
        if (counter_enable_bit_ff && src_tick) begin
          psc_cnt_ff <= psc_wrap ? `ATB_ZERO16 : psc_cnt_ff + `ATB_ONE16;
        end
        cnt_ff <= nxt_cnt;
        if (center) begin
          dir_ff <= nxt_dir;
        end else if (wr_en && paddr_i == `ATB_CTL_OFS) begin
          dir_ff <= pwdata_i[`ATB_CTL_DIR];
        end
        if (nxt_ovf | nxt_udf) begin
          rep_cnt_ff <= rep_zero ? rep_act_ff : rep_cnt_ff - 8'h01;
        end
        if (wr_en && paddr_i == `ATB_CNT_OFS) cnt_ff <= pwdata_i[CW-1:0];
      end
      if (upd) begin
        psc_act_ff <= psc_pre_ff;
        car_act_ff <= car_pre_ff;
        rep_act_ff <= rep_pre_ff;
        if (cnt_upd && !soft_update_generate) rep_cnt_ff <= rep_pre_ff;
      end
    end
  end

  // ************************************************************
  // APB register file
  // ************************************************************
  // Writing one to the status flag does nothing; only a zero clears it,
  // and an update in the same cycle keeps the flag set.
  // Software writes; flag set wins over clear
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      counter_enable_bit_ff <= 1'b0;
      update_disable_ff <= 1'b0;
      center_align_select_ff <= 2'h0;
      slave_mode_select_ff <= `ATB_SMC_INT;
      ext_clock_mode1_en_ff <= 1'b0;
      trigger_source_select_ff <= 4'h0;
      edge_falling_ff <= 8'h00;
      psc_pre_ff <= `ATB_ZERO16;
      car_pre_ff <= `ATB_CAR_RST;
      rep_pre_ff <= 8'h00;
      update_int_flag_ff <= 1'b0;
    end else begin
      if (wr_en) begin
        case (paddr_i)
          `ATB_CTL_OFS: begin
            counter_enable_bit_ff <= pwdata_i[`ATB_CTL_CEN];
            update_disable_ff <= pwdata_i[`ATB_CTL_UPDATE_DISABLE];
            center_align_select_ff <= pwdata_i[`ATB_CTL_CAM_HI:`ATB_CTL_CAM_LO];
          end
          `ATB_SMCFG_OFS: begin
            slave_mode_select_ff <= pwdata_i[`ATB_SMC_HI:`ATB_SMC_LO];
            ext_clock_mode1_en_ff <= pwdata_i[`ATB_EXT_CLOCK_MODE1_EN];
            trigger_source_select_ff <= pwdata_i[`ATB_TRG_HI:`ATB_TRG_LO];
            edge_falling_ff <= pwdata_i[15:8];
          end
          `ATB_STAT_OFS: begin
            if (!pwdata_i[`ATB_STAT_UPDATE_INT_FLAG]) update_int_flag_ff <= 1'b0;
          end
          `ATB_PSC_OFS: psc_pre_ff <= pwdata_i[CW-1:0];
          `ATB_CAR_OFS: car_pre_ff <= pwdata_i[CW-1:0];
          `ATB_REPETITION_COUNT_OFS: rep_pre_ff <= pwdata_i[7:0];
          default: begin
          end
        endcase
      end
      if (upd) update_int_flag_ff <= 1'b1;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // Read data captured in setup phase; it then stands until the next
  // read setup, so a slow master still sees a stable word.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr_i)
        `ATB_CTL_OFS: rdata_ff <= {27'h0, center_align_select_ff, dir_ff,
                                   update_disable_ff, counter_enable_bit_ff};
        `ATB_SMCFG_OFS: rdata_ff <= {16'h0, edge_falling_ff, trigger_source_select_ff,
                                     ext_clock_mode1_en_ff, slave_mode_select_ff};
        `ATB_STAT_OFS: rdata_ff <= {31'h0, update_int_flag_ff};
        `ATB_CNT_OFS: rdata_ff <= {16'h0, cnt_ff};
        `ATB_PSC_OFS: rdata_ff <= {16'h0, psc_pre_ff};
        `ATB_CAR_OFS: rdata_ff <= {16'h0, car_pre_ff};
        `ATB_REPETITION_COUNT_OFS: rdata_ff <= {24'h0, rep_pre_ff};
        default: rdata_ff <= 32'h00000000;
      endcase
    end
  end
  assign prdata_o = rdata_ff;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  // Zero wait states: the read word is already stable when penable rises.

endmodule
`default_nettype wire

/* File: testbench/atb_time_base_props.sv */
// Port checker for the timer time base
`default_nettype none
module atb_time_base_props #(
  parameter CW = 16,
  parameter NCH = 8,
  parameter NITI = 4
) (
  // Clock, reset and bus
  input wire clk_i,
  input wire nrst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // Events
  input wire overflow_o,
  input wire underflow_o,
  input wire update_event_o,
  input wire counter_clock_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Soft update strobe as it lands on the bus
  wire sw_wr = psel_i & penable_i & pwrite_i & (paddr_i == 12'h008) & pwdata_i[0];
  AST_ZERO_WAIT: assert property (psel_i && penable_i |-> pready_o)
    else $error("access phase without ready");
  AST_NO_ERR: assert property (psel_i && penable_i |-> !pslverr_o)
    else $error("slave error raised");
  AST_OVF_STEP: assert property (overflow_o |-> $past(counter_clock_o))
    else $error("overflow without counter step");
  AST_UDF_STEP: assert property (underflow_o |-> $past(counter_clock_o))
    else $error("underflow without counter step");
  AST_UPD_ROOT: assert property (update_event_o |->
    overflow_o || underflow_o || $past(sw_wr) || $past(sw_wr, 2))
    else $error("update without a cause");
  AST_ONE_EVENT: assert property (!(overflow_o && underflow_o))
    else $error("overflow and underflow together");
  AST_OVF_SHORT: assert property (overflow_o |=> !overflow_o)
    else $error("overflow longer than one cycle");
  AST_RD_HOLD: assert property ($changed(prdata_o) |-> $past(psel_i && !penable_i && !pwrite_i))
    else $error("read data moved outside a read");
  // Main scenarios reached
  COV_OVF: cover property (overflow_o);
  COV_UDF: cover property (underflow_o);
  COV_SW: cover property (update_event_o && $past(sw_wr));
endmodule
bind atb_time_base atb_time_base_props #(.CW(CW), .NCH(NCH), .NITI(NITI)) u_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .overflow_o(overflow_o),
  .underflow_o(underflow_o), .update_event_o(update_event_o),
  .counter_clock_o(counter_clock_o));
`default_nettype wire

/* File: testbench/atb_src_model.sv */
// Stand-in for channel pins and trigger sources
`default_nettype none
module atb_src_model (
  input wire logic clk_i,
  output logic [7:0] pin_o,
  output logic [3:0] iti_o,
  output logic eti_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pin_o = 8'h00;
    iti_o = 4'h0;
    eti_o = 1'b0;
  end
  // Pulses 3 cycles wide, so the synchroniser sees every edge
  task automatic burst(input int k, input int i, input int n);
    repeat (n) begin
      @(posedge clk_i);
      if (k == 0) pin_o[i] <= 1'b1;
      else if (k == 1) iti_o[i] <= 1'b1;
      else eti_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      pin_o <= 8'h00;
      iti_o <= 4'h0;
      eti_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

/* File: testbench/atb_time_base_bench.sv */
// Self-checking bench for the timer time base
`default_nettype none
module atb_time_base_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, q;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, overflow_o, underflow_o, update_event_o, counter_clock_o;
  wire [7:0] pin;
  wire [3:0] iti;
  wire ext_trigger_input;
  int fails = 0, samples_checked = 0, n_ck = 0, n_ov = 0, n_un = 0, n_up = 0;
  always #20 clk_i = ~clk_i;
  atb_time_base u_atb_time_base (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ext_channel_pin_i(pin), .internal_trigger_in_i(iti), .ext_trigger_input_i(ext_trigger_input),
    .overflow_o(overflow_o), .underflow_o(underflow_o), .update_event_o(update_event_o),
    .counter_clock_o(counter_clock_o));
  atb_src_model u_atb_src_model (.clk_i(clk_i), .pin_o(pin), .iti_o(iti), .eti_o(ext_trigger_input));
  // Tallies taken mid-cycle, clear of the edge that launches them
  always @(negedge clk_i) begin
    n_ck += (counter_clock_o === 1'b1);
    n_ov += (overflow_o === 1'b1);
    n_un += (underflow_o === 1'b1);
    n_up += (update_event_o === 1'b1);
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (pready_o !== 1'b1 && i < 16);
    if (pready_o !== 1'b1) begin
      fails++;
      $display("[ERR] %0t bus hang", $time);
      close_out();
    end
    q = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Event counts over a window of n cycles
  task automatic span(input int n, input int ck, input int ov, input int un, input int up);
    int a, b, c, e;
    a = n_ck;
    b = n_ov;
    c = n_un;
    e = n_up;
    repeat (n) @(posedge clk_i);
    chk(n_ck - a, ck);
    chk(n_ov - b, ov);
    chk(n_un - c, un);
    chk(n_up - e, up);
  endtask
  // Stop, load preloads, soft update, check start value, run
  task automatic cfg(input logic [31:0] ctl, prescaler_value, auto_reload_value, repetition_count, cnt0);
    apb(1'b1, 12'h000, ctl & 32'hFFFF_FFFE);
    apb(1'b1, 12'h014, prescaler_value);
    apb(1'b1, 12'h018, auto_reload_value);
    apb(1'b1, 12'h01C, repetition_count);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk(q, cnt0);
    apb(1'b1, 12'h000, ctl);
    repeat (12) @(posedge clk_i);
  endtask
  task automatic t_reset();
    apb(1'b0, 12'h018, 32'h0);
    chk(q, 32'h0000_FFFF);
    apb(1'b0, 12'h010, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, 12'h020, 32'h5A);
    apb(1'b0, 12'h020, 32'h0);
    chk(q, 32'h0);
    span(20, 0, 0, 0, 0);
  endtask
  task automatic t_presc();
    cfg(32'h1, 32'h0, 32'h4, 32'h0, 32'h0);
    span(50, 50, 10, 0, 10);
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b1, 12'h014, 32'h2);
    span(50, 50, 10, 0, 0);
    apb(1'b1, 12'h000, 32'h1);
    repeat (20) @(posedge clk_i);
    span(150, 50, 10, 0, 10);
  endtask
  task automatic t_modes();
    cfg(32'h1, 32'h0, 32'h4, 32'h1, 32'h0);
    span(60, 60, 12, 0, 6);
    cfg(32'h5, 32'h0, 32'h4, 32'h0, 32'h4);
    span(50, 50, 0, 10, 10);
    cfg(32'h9, 32'h0, 32'h4, 32'h0, 32'h0);
    span(80, 80, 10, 10, 20);
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h000, 32'hC);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0000_0008);
  endtask
  task automatic t_hold();
    logic [31:0] x;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    x = q;
    span(30, 0, 0, 0, 0);
    apb(1'b0, 12'h010, 32'h0);
    chk(q, x);
    apb(1'b0, 12'h00C, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, 12'h00C, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(q, 32'h0);
  endtask
  // Slave setup, source kind, line index, expected ticks
  task automatic t_src();
    logic [31:0] sm [9] = '{32'h07, 32'h37, 32'h77, 32'h08, 32'h47, 32'h87, 32'h147,
                            32'h07, 32'h04};
    int kd [9] = '{1, 1, 2, 2, 0, 0, 0, 2, 2};
    int ix [9] = '{0, 3, 0, 0, 0, 3, 0, 0, 0};
    int ex [9] = '{6, 6, 6, 6, 6, 6, 6, 0, 48};
    int a;
    cfg(32'h1, 32'h0, 32'h4, 32'h0, 32'h0);
    for (int j = 0; j < 9; j++) begin
      apb(1'b1, 12'h004, sm[j]);
      repeat (8) @(posedge clk_i);
      a = n_ck;
      u_atb_src_model.burst(kd[j], ix[j], 6);
      repeat (6) @(posedge clk_i);
      chk(n_ck - a, ex[j]);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_presc();
    t_modes();
    t_hold();
    t_src();
    close_out();
  end
endmodule
`default_nettype wire
